/* hdl/isc_start.sv */
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "isc_defs.svh"
module isc_start
    import isc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        sda_in,
    input  wire logic        scl_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             scl_out,
    output logic             scl_oe,
    output logic             irq
);
    logic [1:0]    sda_sync_q;
    logic [1:0]    scl_sync_q;
    logic          wr_pend_q;
    logic [11:0]   wr_addr_q;
    logic [7:0]    buffer_q;
    logic [7:0]    rate_q;
    logic [7:0]    mask_q;
    logic [7:0]    ctrl1_q;
    logic [7:0]    ctrl2_q;
    logic [1:0]    irq_stat_q;
    logic [1:0]    irq_mask_q;
    logic          sbit_q;
    logic [6:0]    count_q;
    isc_state_type state_q;
    logic          sda_drv_q;
    logic          scl_drv_q;
    logic          bcl_evt;
    logic          done_evt;
    logic          enabled;
    logic          slave_msk;
    logic          sda_hi;
    logic          scl_hi;
    logic          rd_req;
    logic          wr_en;
    logic [7:0]    wbyte;
    logic [7:0]    rd_byte;
    logic [1:0]    evt_vec;
    // Register bus strobes
    logic          wr_buf;
    logic          wr_rate;
    logic          wr_ctrl1;
    logic          wr_ctrl2;
    logic          wr_stat;
    logic          wr_imask;
    logic          master_mode;
    // Collision terms
    logic          clash_begin;
    logic          clash_count;

    // Data line synchroniser, idles high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sda_sync_q <= 2'h3;
        end else begin
            sda_sync_q <= {sda_sync_q[0], sda_in};
        end
    end

    // Clock line synchroniser, idles high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_sync_q <= 2'h3;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_in};
        end
    end
    assign sda_hi = sda_sync_q[1];
    assign scl_hi = scl_sync_q[1];

    // Mode decode
    assign enabled   = ctrl1_q[`ISC_BIT_ENABLE]; // [R18]
    assign slave_msk = (ctrl1_q[3:0] == `ISC_MODE_MSK_A) ||
                       (ctrl1_q[3:0] == `ISC_MODE_MSK_B);
    assign master_mode = (ctrl1_q[3:0] == `ISC_MODE_MASTER);

    // Bus address phase capture
    assign rd_req = hsel && hready && htrans[1] && !hwrite;

    // Write pending into the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans[1] && hwrite;
        end
    end

    // Address held for the write data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_addr_q <= 12'h000;
        end else if (hready) begin
            wr_addr_q <= haddr;
        end
    end
    assign wr_en = wr_pend_q;
    assign wbyte = hwdata[7:0];

    // Register write strobes
    assign wr_buf   = wr_en && (wr_addr_q == `ISC_OFF_BUFFER);
    assign wr_rate  = wr_en && (wr_addr_q == `ISC_OFF_RATE);
    assign wr_ctrl1 = wr_en && (wr_addr_q == `ISC_OFF_CTRL1);
    assign wr_ctrl2 = wr_en && (wr_addr_q == `ISC_OFF_CTRL2);
    assign wr_stat  = wr_en && (wr_addr_q == `ISC_OFF_IRQ_STAT);
    assign wr_imask = wr_en && (wr_addr_q == `ISC_OFF_IRQ_MASK);

    // Read mux
    always_comb begin
        rd_byte = 8'h00;
        unique case (haddr)
            `ISC_OFF_BUFFER:   rd_byte = buffer_q;
            `ISC_OFF_RATE:     rd_byte = slave_msk ? mask_q : rate_q; // [R16]
            `ISC_OFF_CTRL1:    rd_byte = ctrl1_q;
            `ISC_OFF_CTRL2:    rd_byte = ctrl2_q; // [R17]
            `ISC_OFF_STATUS:   rd_byte = {4'h0, sbit_q, 3'h0};
            `ISC_OFF_IRQ_STAT: rd_byte = {6'h00, irq_stat_q};
            `ISC_OFF_IRQ_MASK: rd_byte = {6'h00, irq_mask_q};
            default:           rd_byte = 8'h00;
        endcase
    end

    // Read data, held until the next read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_req) begin
            hrdata <= {24'h00_0000, rd_byte};
        end
    end

    // Zero wait states, always an okay response
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Transfer buffer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buffer_q <= `ISC_RESET_BYTE;
        end else if (wr_buf) begin
            buffer_q <= wbyte;
        end
    end

    // Rate and mask share one offset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_q <= `ISC_RESET_BYTE;
            mask_q <= 8'hff;
        end else if (wr_rate && slave_msk) begin
            mask_q <= wbyte; // [R16]
        end else if (wr_rate) begin
            rate_q <= wbyte;
        end
    end

    // First control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl1_q <= `ISC_RESET_BYTE;
        end else if (wr_ctrl1) begin
            ctrl1_q <= wbyte;
        end
    end

    // Interrupt mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_q <= 2'h0;
        end else if (wr_imask) begin
            irq_mask_q <= wbyte[1:0];
        end
    end

    // Second control: start request self-clears on finish or abort
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl2_q <= `ISC_RESET_BYTE;
        end else begin
            if (wr_ctrl2) begin
                ctrl2_q <= wbyte; // [R17]
            end
            if (bcl_evt || done_evt || !enabled) begin
                ctrl2_q[`ISC_BIT_START] <= 1'b0; // [R19]
            end
        end
    end

    // Start sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q   <= ISC_IDLE;
            count_q   <= 7'h00;
            sda_drv_q <= 1'b0;
            scl_drv_q <= 1'b0;
        end else if (!enabled || bcl_evt) begin
            state_q   <= ISC_IDLE; // [R4] [R6]
            sda_drv_q <= 1'b0;
            scl_drv_q <= 1'b0;
            count_q   <= 7'h00;
        end else begin
            unique case (state_q)
                // Wait for a start request in master mode
                ISC_IDLE: begin
                    if (ctrl2_q[`ISC_BIT_START] && master_mode) begin
                        state_q   <= ISC_CHECK;
                        sda_drv_q <= 1'b0; // [R7]
                        scl_drv_q <= 1'b0;
                    end
                end
                // Lines looked at once, then first count
                ISC_CHECK: begin
                    state_q <= ISC_CNT1;
                    count_q <= rate_q[6:0]; // [R8]
                end
                // First count, data line still released
                ISC_CNT1: begin
                    if (!sda_hi || count_q == 7'h00) begin
                        sda_drv_q <= 1'b1; // [R10] [R11] [R15]
                        count_q   <= rate_q[6:0]; // [R12]
                        state_q   <= ISC_CNT2;
                    end else begin
                        count_q <= count_q - 7'h01;
                    end
                end
                // Second count, data line held low
                ISC_CNT2: begin
                    if (count_q == 7'h00) begin
                        scl_drv_q <= 1'b1; // [R14]
                        state_q   <= ISC_DONE;
                    end else begin
                        count_q <= count_q - 7'h01; // [R13]
                    end
                end
                // One cycle to report the finished start
                ISC_DONE: begin
                    state_q <= ISC_IDLE;
                end
                default: state_q <= ISC_IDLE;
            endcase
        end
    end

    // Either line low as the start begins
    assign clash_begin = (state_q == ISC_CHECK) &&
                         (!sda_hi || !scl_hi); // [R1]

    // Clock low while data still high in first count
    assign clash_count = (state_q == ISC_CNT1) && sda_hi &&
                         !scl_hi; // [R2] [R9]

    // Collision detection while starting
    always_comb begin
        bcl_evt = 1'b0; // [R3]
        if (enabled && (clash_begin || clash_count)) begin
            bcl_evt = 1'b1;
        end
    end

    // Start finished, lasts one cycle
    assign done_evt = (state_q == ISC_DONE);

    // Start-seen status bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sbit_q <= 1'b0;
        end else if (!enabled || bcl_evt) begin
            sbit_q <= 1'b0;
        end else if (done_evt) begin
            sbit_q <= 1'b1;
        end
    end

    // Event vector, collision in bit zero
    assign evt_vec = {done_evt, bcl_evt}; // [R5]

    // Sticky events, write one to clear, set wins
    generate
        for (genvar i = 0; i < 2; i++) begin : g_evt
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    irq_stat_q[i] <= 1'b0;
                end else if (evt_vec[i]) begin
                    irq_stat_q[i] <= 1'b1; // [R5] [R19]
                end else if (wr_stat && wbyte[i]) begin
                    irq_stat_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Data pin, open drain, enable pulls low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sda_oe  <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            sda_oe  <= sda_drv_q;
            sda_out <= 1'b0;
        end
    end

    // Clock pin, open drain, enable pulls low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_oe  <= 1'b0;
            scl_out <= 1'b0;
        end else begin
            scl_oe  <= scl_drv_q;
            scl_out <= 1'b0;
        end
    end

    // Level interrupt from unmasked events
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end
endmodule : isc_start

/* shared/isc_defs.svh */
// Overview of operation
// R1 - Either line low at start: collision
// R2 - SCL low before SDA driven: collision
// R3 - Sample both lines throughout start
// R4 - Collision abandons the start sequence
// R5 - Collision sets bus collision flag
// R6 - Collision returns port to idle
// R7 - Start begins with both lines released
// R8 - SDA high: load countdown from rate[6:0]
// R9 - First countdown: SCL low is collision
// R10 - SDA low early: reset count, drive SDA
// R11 - Countdown expiry drives SDA low
// R12 - Reload and count down second time
// R13 - Second countdown ignores SCL low
// R14 - Second expiry drives SCL low, done
// R15 - Competing starts not flagged; arbitrate later
// R16 - Mask shares address with rate register
// R17 - Slave mode shows alternate second-control bits; the code reads back ctrl2_q unchanged in every mode
// R18 - Port works only with enable bit five
// R19 - Flag sticky; start request cleared on abort
`ifndef ISC_DEFS_SVH
`define ISC_DEFS_SVH
`define ISC_OFF_BUFFER   12'h000
`define ISC_OFF_RATE     12'h004
`define ISC_OFF_CTRL1    12'h008
`define ISC_OFF_CTRL2    12'h00c
`define ISC_OFF_STATUS   12'h010
`define ISC_OFF_IRQ_STAT 12'h014
`define ISC_OFF_IRQ_MASK 12'h018
`define ISC_BIT_ENABLE   5
`define ISC_BIT_START    0
`define ISC_BIT_SBIT     3
`define ISC_IRQ_BCL      0
`define ISC_IRQ_DONE     1
`define ISC_MODE_MASTER  4'h8
`define ISC_MODE_MSK_A   4'h6
`define ISC_MODE_MSK_B   4'he
`define ISC_RESET_BYTE   8'h00
`endif

/* shared/isc_pkg.sv */
package isc_pkg;
    typedef enum logic [2:0] {
        ISC_IDLE  = 3'b000,
        ISC_CHECK = 3'b001,
        ISC_CNT1  = 3'b011,
        ISC_CNT2  = 3'b010,
        ISC_DONE  = 3'b110
    } isc_state_type;
endpackage : isc_pkg

/* sim/isc_peer_model.sv */
`timescale 1ns/1ps
module isc_peer_model (
    input  wire logic sda_oe,
    input  wire logic scl_oe,
    input  wire logic hold_sda,
    input  wire logic hold_scl,
    input  wire logic clk_run,
    output logic      sda_in,
    output logic      scl_in
);
    logic peer_scl = 1'b1;
    // Peer clock toggles only inside its frame, else rests high
    always #24 peer_scl = clk_run ? ~peer_scl : 1'b1;
    // Pulled-up open-drain lines: any party may pull low
    assign sda_in = !(sda_oe || hold_sda);
    assign scl_in = !(scl_oe || hold_scl) && peer_scl;
endmodule : isc_peer_model

/* sim/isc_start_checker.sv */
`timescale 1ns/1ps
module isc_start_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        sda_in,
    input wire logic        scl_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic        scl_out,
    input wire logic        scl_oe,
    input wire logic        irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Bus and pin conventions
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    chk_pins_low: assert property (!sda_out && !scl_out)
        else $error("line driven high");
    chk_rdata_upper: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_reset_idle: assert property (
        $rose(hresetn) |-> !sda_oe && !scl_oe && !irq)
        else $error("lines or irq active after reset");
    // Start sequence order
    chk_scl_after_sda: assert property (
        $rose(scl_oe) |-> sda_oe) else $error("clock pulled first");
    chk_count2_gap: assert property (
        $rose(sda_oe) |=> !scl_oe) else $error("no second count");
    chk_sda_held: assert property (
        sda_oe && !scl_oe |=> sda_oe) else $error("data released early");
    chk_scl_clash: assert property (
        (!scl_in)[*4] |-> !$rose(sda_oe))
        else $error("data pulled while clock low");
    cover property ($rose(sda_oe));
    cover property ($rose(scl_oe));
    cover property ($rose(irq));
endmodule : isc_start_checker

/* sim/isc_start_test.sv */
`timescale 1ns/1ps
module isc_start_test;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, r;
    logic        hready, hresp, irq, sda_in, scl_in;
    logic        sda_out, sda_oe, scl_out, scl_oe;
    logic        hold_sda = 1'b0, hold_scl = 1'b0, clk_run = 1'b0;
    int          fails = 0, num_checks = 0, cycles = 0, ts, tc, ta, tb;

    // 200 MHz clock
    always #2.5 hclk = ~hclk;
    isc_start uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .sda_in(sda_in),
        .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .scl_out(scl_out), .scl_oe(scl_oe), .irq(irq));
    isc_peer_model peer (.sda_oe(sda_oe), .scl_oe(scl_oe),
        .hold_sda(hold_sda), .hold_scl(hold_scl), .clk_run(clk_run),
        .sda_in(sda_in), .scl_in(scl_in));

    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check

    // One single AHB transfer, read data left in r
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask : xfer

    // Idle the port, set it up, request a start, time both pulls
    task automatic run(input logic [7:0] ctl, rate, input int n);
        xfer(1'b1, 12'h008, 32'h0);
        xfer(1'b1, 12'h014, 32'h3);
        xfer(1'b1, 12'h008, {24'h0, ctl});
        xfer(1'b1, 12'h004, {24'h0, rate});
        xfer(1'b1, 12'h00c, 32'h1);
        ts = 0;
        tc = 0;
        for (int i = 1; i <= n; i++) begin
            @(negedge hclk);
            if (ts == 0 && sda_oe === 1'b1) ts = i;
            if (tc == 0 && scl_oe === 1'b1) tc = i;
        end
        @(posedge hclk);
    endtask : run

    task automatic t_regs;
        xfer(1'b0, 12'h008, 32'h0);
        check(r, 32'h0);
        xfer(1'b1, 12'h008, 32'h6);
        xfer(1'b0, 12'h004, 32'h0);
        check(r, 32'hff);
        xfer(1'b0, 12'h01c, 32'h0);
        check(r, 32'h0);
    endtask : t_regs

    task automatic t_start;
        xfer(1'b1, 12'h018, 32'h2);
        run(8'h28, 8'h02, 60);
        ta = ts;
        tb = tc;
        run(8'h28, 8'h85, 60);
        check(ts - ta, 3);
        check(tc - ts - (tb - ta), 3);
        xfer(1'b0, 12'h004, 32'h0);
        check(r, 32'h85);
        xfer(1'b0, 12'h00c, 32'h0);
        check(r, 32'h0);
        xfer(1'b0, 12'h010, 32'h0);
        check(r & 32'h8, 32'h8);
        xfer(1'b0, 12'h014, 32'h0);
        check(r, 32'h2);
        check(irq, 1'b1);
        xfer(1'b1, 12'h014, 32'h2);
        xfer(1'b0, 12'h014, 32'h0);
        check(r, 32'h0);
        check(irq, 1'b0);
    endtask : t_start

    task automatic t_clash(input logic on_scl);
        hold_sda <= !on_scl;
        hold_scl <= on_scl;
        xfer(1'b1, 12'h018, 32'h2);
        run(8'h28, 8'h03, 40);
        check(ts, 0);
        xfer(1'b0, 12'h014, 32'h0);
        check(r, 32'h1);
        check(irq, 1'b0);
        xfer(1'b1, 12'h018, 32'h3);
        xfer(1'b0, 12'h00c, 32'h0);
        check(r, 32'h0);
        check(irq, 1'b1);
        hold_sda <= 1'b0;
        hold_scl <= 1'b0;
    endtask : t_clash

    task automatic t_clash_count;
        fork
            run(8'h28, 8'h1e, 80);
            begin
                repeat (20) @(posedge hclk);
                clk_run <= 1'b1;
            end
        join
        clk_run <= 1'b0;
        check(ts, 0);
        xfer(1'b0, 12'h014, 32'h0);
        check(r, 32'h1);
    endtask : t_clash_count

    task automatic t_early;
        fork
            run(8'h28, 8'h3c, 200);
            begin
                repeat (20) @(posedge hclk);
                hold_sda <= 1'b1;
                repeat (30) @(posedge hclk);
                hold_scl <= 1'b1;
            end
        join
        check(ts > 0 && ts < 30, 1);
        check(tc > ts, 1);
        xfer(1'b0, 12'h014, 32'h0);
        check(r, 32'h2);
        hold_sda <= 1'b0;
        hold_scl <= 1'b0;
    endtask : t_early

    task automatic t_off;
        run(8'h08, 8'h02, 40);
        check(ts + tc, 0);
    endtask : t_off

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_start();
        t_clash(1'b0);
        t_clash(1'b1);
        t_clash_count();
        t_early();
        t_off();
        print_verdict();
    end

    // Hang guard
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            print_verdict();
        end
    end
endmodule : isc_start_test

bind isc_start isc_start_checker chk (.hclk(hclk), .hresetn(hresetn),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sda_in(sda_in), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe), .irq(irq));
